// >>> src/srh_defs.vh
/*
  Constants for the host-side controller of a 1024 x 4 asynchronous static
  memory with one shared data bus, active-low chip select and write strobe.
  Assumes a single 20 MHz system clock; times below are in ns, except SRH_SYNC_CYC, which is in cycles.
*/
// Operation
// - For a read, host keeps write strobe high while chip select is low.
// - Address is valid before or when chip select falls in a read.
// - Host never drives data against the memory's own driven outputs.
// - Write strobe rising with select low re-enables outputs; host must not fight.
`ifndef SRH_DEFS_VH
`define SRH_DEFS_VH

`define SRH_ADDR_W 10
`define SRH_DATA_W 4

// Sized to the 16-bit argument of the cycle conversion
`define SRH_CLK_NS 16'h0032

// Slowest speed grade, so any grade fitted on the board works
`define SRH_T_AA_NS 16'h0037
`define SRH_T_WP_NS 16'h0028
`define SRH_T_CW_NS 16'h0032
`define SRH_T_DW_NS 16'h0014
`define SRH_T_WR_NS 16'h0005
`define SRH_T_HZ_NS 16'h0014
`define SRH_T_WZ_NS 16'h0014

// Three synchroniser stages plus the agreement register; sized to the counter
`define SRH_SYNC_CYC 8'h04

`define SRH_CNT_W 8

`endif

// >>> src/srh_sync.v
/*
  Three-stage input synchroniser for the memory data pins.
  Assumes the pins are asynchronous to clk; the filtered value moves only
  when the second and third stages agree.
*/
`timescale 1ns/10ps
`include "srh_defs.vh"

module srh_sync (
  input wire clk,
  input wire reset_n,
  input wire [`SRH_DATA_W-1:0] pin_in,
  output reg [`SRH_DATA_W-1:0] value_r
);

  reg [`SRH_DATA_W-1:0] s1_r;
  reg [`SRH_DATA_W-1:0] s2_r;
  reg [`SRH_DATA_W-1:0] s3_r;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_r <= {`SRH_DATA_W{1'b0}};
      s2_r <= {`SRH_DATA_W{1'b0}};
      s3_r <= {`SRH_DATA_W{1'b0}};
      value_r <= {`SRH_DATA_W{1'b0}};
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // A bit caught mid-transition in one stage is not passed on
      if (s2_r == s3_r) begin
        value_r <= s3_r;
      end
    end
  end

endmodule

// >>> src/srh_ctrl.v
/*
  Host-side controller for a 1024 x 4 asynchronous static memory.
  Takes one read or write request at a time from user logic and sequences
  address, chip select, write strobe and the shared data bus.
  Assumes the memory pins are wired directly, one 20 MHz clock, and that the
  board resolves the data wire from sram_dq_out and sram_dq_oe.
*/
`timescale 1ns/10ps
`include "srh_defs.vh"

module srh_ctrl (
  input wire clk,
  input wire reset_n,
  input wire req,
  input wire req_write,
  input wire req_verify,
  input wire [`SRH_ADDR_W-1:0] req_addr,
  input wire [`SRH_DATA_W-1:0] req_wdata,
  output reg ready_r,
  output reg done_r,
  output reg rd_valid_r,
  output reg [`SRH_DATA_W-1:0] rd_data_r,
  output reg verify_fail_r,
  output reg [`SRH_ADDR_W-1:0] sram_addr_r,
  output reg sram_cs_n_r,
  output reg sram_we_n_r,
  output reg [`SRH_DATA_W-1:0] sram_dq_out_r,
  output reg sram_dq_oe_r,
  input wire [`SRH_DATA_W-1:0] sram_dq_in
);

  // Least times round up to whole cycles, never below one
  function [`SRH_CNT_W-1:0] ns_to_cyc;
    input [15:0] ns;
    reg [15:0] tmp;
    begin
      tmp = (ns + `SRH_CLK_NS - 16'h0001) / `SRH_CLK_NS;
      if (tmp == 16'd0) begin
        tmp = 16'd1;
      end
      ns_to_cyc = tmp[`SRH_CNT_W-1:0];
    end
  endfunction

  function [`SRH_CNT_W-1:0] max_cyc;
    input [`SRH_CNT_W-1:0] a;
    input [`SRH_CNT_W-1:0] b;
    begin
      max_cyc = (a > b) ? a : b;
    end
  endfunction

  localparam [`SRH_CNT_W-1:0] AA_CYC = ns_to_cyc(`SRH_T_AA_NS);
  localparam [`SRH_CNT_W-1:0] SYNC_CYC = `SRH_SYNC_CYC;
  localparam [`SRH_CNT_W-1:0] RD_CYC = AA_CYC + SYNC_CYC;
  localparam [`SRH_CNT_W-1:0] PUL_CYC =
    max_cyc(max_cyc(ns_to_cyc(`SRH_T_WP_NS), ns_to_cyc(`SRH_T_CW_NS)),
            ns_to_cyc(`SRH_T_DW_NS));
  localparam [`SRH_CNT_W-1:0] TURN_CYC =
    max_cyc(max_cyc(ns_to_cyc(`SRH_T_HZ_NS), ns_to_cyc(`SRH_T_WZ_NS)),
            ns_to_cyc(`SRH_T_WR_NS));
  localparam [`SRH_CNT_W-1:0] CNT_ONE = {{(`SRH_CNT_W-1){1'b0}}, 1'b1};

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_RD_SET = 3'h1;
  localparam [2:0] ST_RD_ACC = 3'h2;
  localparam [2:0] ST_WR_SET = 3'h3;
  localparam [2:0] ST_WR_PUL = 3'h4;
  localparam [2:0] ST_WR_END = 3'h5;
  localparam [2:0] ST_TURN = 3'h6;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [`SRH_CNT_W-1:0] cnt_r;
  reg [`SRH_CNT_W-1:0] cnt_nxt;
  reg vpend_r;
  reg vpend_nxt;
  reg chk_r;
  reg chk_nxt;
  reg ready_nxt;
  reg done_nxt;
  reg rd_valid_nxt;
  reg [`SRH_DATA_W-1:0] rd_data_nxt;
  reg verify_fail_nxt;
  reg [`SRH_ADDR_W-1:0] sram_addr_nxt;
  reg sram_cs_n_nxt;
  reg sram_we_n_nxt;
  reg [`SRH_DATA_W-1:0] sram_dq_out_nxt;
  reg sram_dq_oe_nxt;

  wire [`SRH_DATA_W-1:0] dq_sync;
  wire cnt_last;

  srh_sync u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .pin_in(sram_dq_in),
    .value_r(dq_sync)
  );

  assign cnt_last = (cnt_r == CNT_ONE);

  always @* begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    vpend_nxt = vpend_r;
    chk_nxt = chk_r;
    ready_nxt = ready_r;
    done_nxt = 1'b0;
    rd_valid_nxt = 1'b0;
    rd_data_nxt = rd_data_r;
    verify_fail_nxt = 1'b0;
    sram_addr_nxt = sram_addr_r;
    sram_cs_n_nxt = sram_cs_n_r;
    sram_we_n_nxt = sram_we_n_r;
    sram_dq_out_nxt = sram_dq_out_r;
    sram_dq_oe_nxt = sram_dq_oe_r;
    case (state_r)
      ST_IDLE: begin
        if (req && ready_r) begin
          ready_nxt = 1'b0;
          // Address only moves while deselected
          sram_addr_nxt = req_addr;
          vpend_nxt = req_write & req_verify;
          chk_nxt = 1'b0;
          if (req_write) begin
            // Strobe low and bus driven while the memory is still deselected
            sram_we_n_nxt = 1'b0;
            sram_dq_out_nxt = req_wdata;
            sram_dq_oe_nxt = 1'b1;
            state_nxt = ST_WR_SET;
          end else begin
            sram_we_n_nxt = 1'b1;
            sram_dq_oe_nxt = 1'b0;
            state_nxt = ST_RD_SET;
          end
        end
      end
      ST_RD_SET: begin
        // Address has stood a full cycle before select falls
        sram_cs_n_nxt = 1'b0;
        cnt_nxt = RD_CYC;
        state_nxt = ST_RD_ACC;
      end
      ST_RD_ACC: begin
        if (cnt_last) begin
          sram_cs_n_nxt = 1'b1;
          if (chk_r) begin
            // Read-back after a write must return what was written
            verify_fail_nxt = (dq_sync != sram_dq_out_r);
            chk_nxt = 1'b0;
          end else begin
            rd_data_nxt = dq_sync;
            rd_valid_nxt = 1'b1;
          end
          cnt_nxt = TURN_CYC;
          state_nxt = ST_TURN;
        end else begin
          cnt_nxt = cnt_r - CNT_ONE;
        end
      end
      ST_WR_SET: begin
        // Select falls after the strobe, so memory outputs never turn on
        sram_cs_n_nxt = 1'b0;
        cnt_nxt = PUL_CYC;
        state_nxt = ST_WR_PUL;
      end
      ST_WR_PUL: begin
        if (cnt_last) begin
          // Select rises first: no window where strobe is high and select low
          sram_cs_n_nxt = 1'b1;
          state_nxt = ST_WR_END;
        end else begin
          cnt_nxt = cnt_r - CNT_ONE;
        end
      end
      ST_WR_END: begin
        // Data held past the end of write, then released
        sram_we_n_nxt = 1'b1;
        sram_dq_oe_nxt = 1'b0;
        cnt_nxt = TURN_CYC;
        state_nxt = ST_TURN;
      end
      ST_TURN: begin
        // Bus turnaround; slower than the memory's release time
        if (cnt_last) begin
          if (vpend_r) begin
            vpend_nxt = 1'b0;
            chk_nxt = 1'b1;
            state_nxt = ST_RD_SET;
          end else begin
            done_nxt = 1'b1;
            ready_nxt = 1'b1;
            state_nxt = ST_IDLE;
          end
        end else begin
          cnt_nxt = cnt_r - CNT_ONE;
        end
      end
      default: begin
        sram_cs_n_nxt = 1'b1;
        sram_we_n_nxt = 1'b1;
        sram_dq_oe_nxt = 1'b0;
        ready_nxt = 1'b1;
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      cnt_r <= {`SRH_CNT_W{1'b0}};
      vpend_r <= 1'b0;
      chk_r <= 1'b0;
      ready_r <= 1'b1;
      done_r <= 1'b0;
      rd_valid_r <= 1'b0;
      rd_data_r <= {`SRH_DATA_W{1'b0}};
      verify_fail_r <= 1'b0;
      sram_addr_r <= {`SRH_ADDR_W{1'b0}};
      sram_cs_n_r <= 1'b1;
      sram_we_n_r <= 1'b1;
      sram_dq_out_r <= {`SRH_DATA_W{1'b0}};
      sram_dq_oe_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      vpend_r <= vpend_nxt;
      chk_r <= chk_nxt;
      ready_r <= ready_nxt;
      done_r <= done_nxt;
      rd_valid_r <= rd_valid_nxt;
      rd_data_r <= rd_data_nxt;
      verify_fail_r <= verify_fail_nxt;
      sram_addr_r <= sram_addr_nxt;
      sram_cs_n_r <= sram_cs_n_nxt;
      sram_we_n_r <= sram_we_n_nxt;
      sram_dq_out_r <= sram_dq_out_nxt;
      sram_dq_oe_r <= sram_dq_oe_nxt;
    end
  end

endmodule

// >>> dv/srh_mem_model.sv
/*
  Behavioural 1024 x 4 static memory with one shared data bus.
  Assumes the host data driver and its enable are fed in, so the wire is resolved here.
*/
`timescale 1ns/10ps
`include "srh_defs.vh"
module srh_mem_model #(
  parameter ACC_NS = 55
) (
  input wire [`SRH_ADDR_W-1:0] addr,
  input wire cs_n,
  input wire we_n,
  input wire [`SRH_DATA_W-1:0] host_dq,
  input wire host_oe,
  input wire flip,
  output wire [`SRH_DATA_W-1:0] dq_wire
);
  reg [`SRH_DATA_W-1:0] mem [0:1023];
  reg [`SRH_DATA_W-1:0] junk;
  integer k;
  wire drv = !cs_n && we_n;
  wire drv_d;
  // Data is valid only once the access time has run
  assign #(ACC_NS) drv_d = drv;
  // Floating bus shows a changing pattern, never a stale value
  assign dq_wire = host_oe ? host_dq : (drv && drv_d) ? mem[addr] : junk;
  initial begin
    junk = 4'hA;
    for (k = 0; k < 1024; k = k + 1) mem[k] = 4'h0;
  end
  always #50 junk = ~junk;
  // Flip corrupts a stored bit only when the bench asks for it
  always @* if (!cs_n && !we_n && host_oe) mem[addr] = host_dq ^ {3'h0, flip};
endmodule

// >>> dv/srh_ctrl_sva.sv
/*
  Checker for the memory pins and request timing of srh_ctrl.
  Assumes it is bound to srh_ctrl and sees only its ports.
*/
`timescale 1ns/10ps
`include "srh_defs.vh"
module srh_ctrl_sva (
  input wire clk,
  input wire reset_n,
  input wire req,
  input wire req_write,
  input wire req_verify,
  input wire [`SRH_ADDR_W-1:0] req_addr,
  input wire [`SRH_DATA_W-1:0] req_wdata,
  input wire ready_r,
  input wire done_r,
  input wire rd_valid_r,
  input wire [`SRH_DATA_W-1:0] rd_data_r,
  input wire verify_fail_r,
  input wire [`SRH_ADDR_W-1:0] sram_addr_r,
  input wire sram_cs_n_r,
  input wire sram_we_n_r,
  input wire [`SRH_DATA_W-1:0] sram_dq_out_r,
  input wire sram_dq_oe_r,
  input wire [`SRH_DATA_W-1:0] sram_dq_in
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_take;
    req && ready_r;
  endsequence
  sequence s_wr_pins;
    !sram_we_n_r && sram_dq_oe_r && sram_cs_n_r ##1 !sram_cs_n_r && !sram_we_n_r
      ##1 sram_cs_n_r && !sram_we_n_r ##1 sram_we_n_r && !sram_dq_oe_r;
  endsequence
  sequence s_rd_pins;
    sram_we_n_r && sram_cs_n_r ##1 (!sram_cs_n_r && sram_we_n_r)[*6]
      ##1 sram_cs_n_r && rd_valid_r;
  endsequence
  AST_WR_WALK: assert property (s_take and req_write |=> s_wr_pins)
    else $error("write pin sequence wrong");
  AST_WR_DATA: assert property (s_take and req_write |=> sram_dq_out_r == $past(req_wdata))
    else $error("write data not presented");
  AST_WR_DONE: assert property (s_take and req_write && !req_verify |-> ##5 done_r)
    else $error("write not done in 5 cycles");
  AST_RD_WALK: assert property (s_take and !req_write |=> s_rd_pins ##1 done_r && ready_r)
    else $error("read pin sequence wrong");
  AST_ADDR_HOLD: assert property (!sram_cs_n_r |-> $stable(sram_addr_r))
    else $error("address moved while selected");
  AST_WE_FIRST: assert property ($fell(sram_cs_n_r) && !sram_we_n_r |-> !$past(sram_we_n_r))
    else $error("select fell before write strobe");
  AST_NO_FIGHT: assert property (sram_dq_oe_r |-> sram_cs_n_r || !sram_we_n_r)
    else $error("host drives against memory");
  AST_VF_DONE: assert property (s_take and req_write && req_verify |-> ##13 done_r)
    else $error("verified write not done in 13 cycles");
  AST_IDLE: assert property (ready_r |-> sram_cs_n_r && !sram_dq_oe_r)
    else $error("bus active while idle");
endmodule
bind srh_ctrl srh_ctrl_sva srh_ctrl_sva_i (.clk(clk), .reset_n(reset_n), .req(req),
  .req_write(req_write), .req_verify(req_verify), .req_addr(req_addr), .req_wdata(req_wdata),
  .ready_r(ready_r), .done_r(done_r), .rd_valid_r(rd_valid_r), .rd_data_r(rd_data_r),
  .verify_fail_r(verify_fail_r), .sram_addr_r(sram_addr_r), .sram_cs_n_r(sram_cs_n_r),
  .sram_we_n_r(sram_we_n_r), .sram_dq_out_r(sram_dq_out_r), .sram_dq_oe_r(sram_dq_oe_r),
  .sram_dq_in(sram_dq_in));

// >>> dv/srh_ctrl_tb.sv
/*
  Self-checking bench for srh_ctrl against a scoreboard of the memory.
  Assumes the memory model resolves the shared data wire.
*/
`timescale 1ns/10ps
`include "srh_defs.vh"
module srh_ctrl_tb;
  reg clk;
  reg reset_n;
  reg req;
  reg req_write;
  reg req_verify;
  reg flip;
  reg [9:0] req_addr;
  reg [3:0] req_wdata;
  wire ready_r, done_r, rd_valid_r, verify_fail_r, cs_n, we_n, dq_oe;
  wire [3:0] rd_data_r, dq_out, dq_in;
  wire [9:0] addr;
  integer miscompares, checks_done, i, n;
  reg [3:0] sb [0:1023];
  srh_ctrl srh_ctrl_i (.clk(clk), .reset_n(reset_n), .req(req), .req_write(req_write),
    .req_verify(req_verify), .req_addr(req_addr), .req_wdata(req_wdata), .ready_r(ready_r),
    .done_r(done_r), .rd_valid_r(rd_valid_r), .rd_data_r(rd_data_r),
    .verify_fail_r(verify_fail_r), .sram_addr_r(addr), .sram_cs_n_r(cs_n), .sram_we_n_r(we_n),
    .sram_dq_out_r(dq_out), .sram_dq_oe_r(dq_oe), .sram_dq_in(dq_in));
  srh_mem_model #(.ACC_NS(55)) srh_mem_model_i (.addr(addr), .cs_n(cs_n), .we_n(we_n),
    .host_dq(dq_out), .host_oe(dq_oe), .flip(flip), .dq_wire(dq_in));
  task check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task conclude;
    if (miscompares == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task op(input logic w, input logic v, input logic f, input logic [9:0] a, input logic [3:0] d);
    integer c;
    integer rv;
    reg vf;
    @(posedge clk);
    req <= 1'b1;
    req_write <= w;
    req_verify <= v;
    req_addr <= a;
    req_wdata <= d;
    flip <= f;
    @(posedge clk);
    req <= 1'b0;
    #1;
    // Counted to the edge that samples done high, taking edge included
    c = 1;
    rv = 0;
    vf = 1'b0;
    while (done_r !== 1'b1 && c < 30) begin
      @(posedge clk);
      #1;
      c = c + 1;
      if (rd_valid_r === 1'b1) begin
        rv = rv + 1;
        check("rd_data", {12'h0, sb[a]}, {12'h0, rd_data_r});
      end
      if (verify_fail_r === 1'b1) vf = 1'b1;
    end
    if (c >= 30) begin
      miscompares = miscompares + 1;
      conclude;
    end
    check("cycles", w ? (v ? 16'd13 : 16'd5) : 16'd9, c[15:0]);
    check("rd_valid_count", w ? 16'd0 : 16'd1, rv[15:0]);
    check("verify_fail", {15'h0, w & v & f}, {15'h0, vf});
    if (w) sb[a] = d ^ {3'h0, f};
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    reset_n = 1'b0;
    req = 1'b0;
    req_write = 1'b0;
    req_verify = 1'b0;
    flip = 1'b0;
    req_addr = 10'h000;
    req_wdata = 4'h0;
    miscompares = 0;
    checks_done = 0;
    for (i = 0; i < 1024; i = i + 1) sb[i] = 4'h0;
    n = $urandom(33);
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    #1;
    check("idle", 16'h0003, {14'h0, ready_r, cs_n & ~dq_oe});
    op(1'b1, 1'b0, 1'b0, 10'h3FF, 4'hF);
    op(1'b0, 1'b0, 1'b0, 10'h3FF, 4'h0);
    op(1'b1, 1'b1, 1'b1, 10'h000, 4'h5);
    op(1'b1, 1'b1, 1'b0, 10'h001, 4'hA);
    op(1'b0, 1'b0, 1'b0, 10'h000, 4'h0);
    for (i = 0; i < 60; i = i + 1) op(1'($urandom), 1'($urandom), 1'b0, 10'($urandom % 8), 4'($urandom));
    conclude;
  end
endmodule
